/* File: logic/drive_state_status_word.sv */
// Purpose: Operating-state signal outputs and 16-bit drive status word
// Assumes: Conditions come from same-clock logic; state machine is outside
// Notes: Read port is combinational address match, data registered
`timescale 1ns/1ps

module drive_state_status_word (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire drive_status_pkg::op_state_t op_state_i,
    input wire drive_status_pkg::status_cond_t cond_i,
    input wire logic dc_bus_ok_i,
    input wire logic internal_limit_meaning_select_i,
    input wire logic req_3_to_4_i,
    input wire logic [15:0] rd_addr_i,
    input wire logic rd_en_i,
    output logic allow_3_to_4_o,
    output logic no_fault_o,
    output logic second_digital_output_o,
    output logic [15:0] drive_status_word_o,
    output logic [15:0] rd_data_o,
    output logic rd_valid_o
);
    import drive_status_pkg::*;

    // ****************************************
    // Class-0 warning hold
    // ****************************************
    logic [WARN_CNT_W-1:0] warn_cnt_ff;
    logic warn_ff;
    logic nxt_warn;
    logic [WARN_CNT_W-1:0] nxt_warn_cnt;
    localparam logic [WARN_CNT_W-1:0] WARN_LOAD =
        WARN_CNT_W'(WARN_HOLD_CYC - 1);

    always_comb begin
        nxt_warn = warn_ff;
        nxt_warn_cnt = warn_cnt_ff;
        // Fault reset wins over a warning in the same cycle
        if (cond_i.fault_reset) begin
            nxt_warn = 1'b0;
            nxt_warn_cnt = '0;
        end else if (cond_i.warn_class0) begin
            nxt_warn = 1'b1;
            if (!warn_ff) begin
                nxt_warn_cnt = WARN_LOAD;
            end else if (warn_cnt_ff != '0) begin
                nxt_warn_cnt = warn_cnt_ff - 1'b1;
            end
        end else if (warn_ff) begin
            if (warn_cnt_ff == '0) begin
                nxt_warn = 1'b0;
            end else begin
                nxt_warn_cnt = warn_cnt_ff - 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            warn_ff <= 1'b0;
            warn_cnt_ff <= '0;
        end else begin
            warn_ff <= nxt_warn;
            warn_cnt_ff <= nxt_warn_cnt;
        end
    end

    // ****************************************
    // Process-end tracking
    // ****************************************
    typedef enum logic [1:0] {
        PE_IDLE = 2'b00,
        PE_RUN = 2'b01,
        PE_STOPPING = 2'b10
    } proc_state_t;

    proc_state_t proc_ff;
    proc_state_t nxt_proc;

    always_comb begin
        case (proc_ff)
            PE_IDLE: begin
                nxt_proc = cond_i.mode_start ? PE_RUN : PE_IDLE;
            end
            PE_RUN: begin
                if (cond_i.new_mode_start) begin
                    nxt_proc = PE_RUN;
                end else if (cond_i.mode_start) begin
                    nxt_proc = PE_RUN;
                end else if (cond_i.mode_stop) begin
                    nxt_proc = cond_i.standstill ? PE_IDLE : PE_STOPPING;
                end else begin
                    nxt_proc = PE_RUN;
                end
            end
            PE_STOPPING: begin
                if (cond_i.mode_start || cond_i.new_mode_start) begin
                    nxt_proc = PE_RUN;
                end else if (cond_i.standstill) begin
                    nxt_proc = PE_IDLE;
                end else begin
                    nxt_proc = PE_STOPPING;
                end
            end
            default: begin
                nxt_proc = PE_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            proc_ff <= PE_IDLE;
        end else begin
            proc_ff <= nxt_proc;
        end
    end

    // ****************************************
    // Zero point
    // ****************************************
    logic ref_ok_ff;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            ref_ok_ff <= 1'b0;
        end else begin
            ref_ok_ff <= cond_i.zero_point_valid;
        end
    end

    // ****************************************
    // Status word assembly
    // ****************************************
    logic [15:0] nxt_status;
    logic [15:0] status_ff;
    logic no_fault_ff;
    logic active_ff;
    logic allow_ff;

    always_comb begin
        nxt_status = STATUS_RESET;
        case (op_state_i)
            ST_SWITCH_ON_DISABLED: begin
                nxt_status[BIT_SOD] = 1'b1;
            end
            ST_READY: begin
                nxt_status[BIT_RTSO] = 1'b1;
                nxt_status[BIT_QSTP] = 1'b1;
            end
            ST_SWITCHED_ON: begin
                nxt_status[BIT_RTSO] = 1'b1;
                nxt_status[BIT_SWON] = 1'b1;
                nxt_status[BIT_QSTP] = 1'b1;
            end
            ST_OP_ENABLED: begin
                nxt_status[BIT_RTSO] = 1'b1;
                nxt_status[BIT_SWON] = 1'b1;
                nxt_status[BIT_OPEN] = 1'b1;
                nxt_status[BIT_QSTP] = 1'b1;
            end
            ST_QUICK_STOP: begin
                nxt_status[BIT_RTSO] = 1'b1;
                nxt_status[BIT_SWON] = 1'b1;
                nxt_status[BIT_OPEN] = 1'b1;
            end
            ST_FAULT_REACTION: begin
                nxt_status[BIT_RTSO] = 1'b1;
                nxt_status[BIT_SWON] = 1'b1;
                nxt_status[BIT_OPEN] = 1'b1;
                nxt_status[BIT_FLT] = 1'b1;
            end
            ST_FAULT: begin
                nxt_status[BIT_FLT] = 1'b1;
            end
            default: begin
                nxt_status = STATUS_RESET;
            end
        endcase
        nxt_status[BIT_VOLT] = dc_bus_ok_i;
        nxt_status[BIT_WARN] = nxt_warn;
        nxt_status[BIT_HALT] = cond_i.halt_active;
        nxt_status[BIT_REM] = cond_i.remote;
        nxt_status[BIT_MODE_A] = cond_i.mode_bit_a;
        nxt_status[BIT_MODE_B] = cond_i.mode_bit_b;
        nxt_status[BIT_ILIM] = internal_limit_meaning_select_i ?
            cond_i.limit_cond_b : cond_i.limit_cond_a;
        nxt_status[BIT_ERR] = cond_i.err_blocking;
        nxt_status[BIT_END] = (nxt_proc == PE_IDLE);
        nxt_status[BIT_REF] = cond_i.zero_point_valid;
    end

    // ****************************************
    // Status word register
    // ****************************************
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            status_ff <= STATUS_RESET;
        end else begin
            status_ff <= nxt_status;
        end
    end

    // ****************************************
    // Operating-state signal outputs
    // ****************************************
    logic nxt_no_fault;
    logic nxt_active;

    always_comb begin
        case (op_state_i)
            ST_READY, ST_SWITCHED_ON, ST_OP_ENABLED: begin
                nxt_no_fault = 1'b1;
            end
            default: begin
                nxt_no_fault = 1'b0;
            end
        endcase
        nxt_active = (op_state_i == ST_OP_ENABLED);
    end

    // Same edge as the status word, so both always agree
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            no_fault_ff <= 1'b0;
            active_ff <= 1'b0;
        end else begin
            no_fault_ff <= nxt_no_fault;
            active_ff <= nxt_active;
        end
    end

    // ****************************************
    // Transition gate from state 3 to 4
    // ****************************************
    logic nxt_allow;

    always_comb begin
        nxt_allow = 1'b0;
        if (op_state_i == ST_SWITCH_ON_DISABLED && req_3_to_4_i) begin
            nxt_allow = dc_bus_ok_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            allow_ff <= 1'b0;
        end else begin
            allow_ff <= nxt_allow;
        end
    end

    // ****************************************
    // Fieldbus read port
    // ****************************************
    logic [15:0] rd_data_ff;
    logic rd_valid_ff;
    logic [15:0] nxt_rd_data;

    // Unmapped addresses read as zero
    always_comb begin
        nxt_rd_data = STATUS_RESET;
        if (rd_en_i && rd_addr_i == DRIVE_STATUS_WORD_OFFSET) begin
            nxt_rd_data = status_ff;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            rd_data_ff <= STATUS_RESET;
            rd_valid_ff <= 1'b0;
        end else begin
            rd_valid_ff <= rd_en_i;
            rd_data_ff <= nxt_rd_data;
        end
    end

    assign allow_3_to_4_o = allow_ff;
    assign no_fault_o = no_fault_ff;
    assign second_digital_output_o = active_ff;
    assign drive_status_word_o = status_ff;
    assign rd_data_o = rd_data_ff;
    assign rd_valid_o = rd_valid_ff;
endmodule

/* File: logic/drive_status_pkg.sv */
// Purpose: Constants and types for the drive status word block
// Assumes: 200 MHz system clock
// Notes: Operating states are numbered as the drive reports them
package drive_status_pkg;
    localparam logic [15:0] DRIVE_STATUS_WORD_OFFSET = 16'h1B04;
    localparam int STATUS_W = 16;
    localparam int BIT_RTSO = 0;
    localparam int BIT_SWON = 1;
    localparam int BIT_OPEN = 2;
    localparam int BIT_FLT = 3;
    localparam int BIT_VOLT = 4;
    localparam int BIT_QSTP = 5;
    localparam int BIT_SOD = 6;
    localparam int BIT_WARN = 7;
    localparam int BIT_HALT = 8;
    localparam int BIT_REM = 9;
    localparam int BIT_MODE_A = 10;
    localparam int BIT_ILIM = 11;
    localparam int BIT_MODE_B = 12;
    localparam int BIT_ERR = 13;
    localparam int BIT_END = 14;
    localparam int BIT_REF = 15;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam int CLK_MHZ = 200;
    localparam int WARN_HOLD_MS = 100;
    localparam int WARN_HOLD_CYC = WARN_HOLD_MS * 1000 * CLK_MHZ;
    localparam int WARN_CNT_W = 25;

    typedef enum logic [3:0] {
        ST_START = 4'h1,
        ST_NOT_READY = 4'h2,
        ST_SWITCH_ON_DISABLED = 4'h3,
        ST_READY = 4'h4,
        ST_SWITCHED_ON = 4'h5,
        ST_OP_ENABLED = 4'h6,
        ST_QUICK_STOP = 4'h7,
        ST_FAULT_REACTION = 4'h8,
        ST_FAULT = 4'h9
    } op_state_t;

    typedef struct packed {
        logic warn_class0;
        logic fault_reset;
        logic halt_active;
        logic remote;
        logic mode_bit_a;
        logic mode_bit_b;
        logic limit_cond_a;
        logic limit_cond_b;
        logic err_blocking;
        logic mode_start;
        logic mode_stop;
        logic new_mode_start;
        logic standstill;
        logic zero_point_valid;
    } status_cond_t;
endpackage

/* File: sim/drive_status_monitor.sv */
// Purpose: Port assertions for the status word block
// Assumes: One clock domain, sync reset
// Notes: Bound to the top module
`timescale 1ns/1ps
module drive_status_monitor
    import drive_status_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire drive_status_pkg::op_state_t op_state_i,
    input wire drive_status_pkg::status_cond_t cond_i,
    input wire logic dc_bus_ok_i,
    input wire logic internal_limit_meaning_select_i,
    input wire logic req_3_to_4_i,
    input wire logic rd_en_i,
    input wire logic allow_3_to_4_o,
    input wire logic no_fault_o,
    input wire logic second_digital_output_o,
    input wire logic [15:0] drive_status_word_o,
    input wire logic rd_valid_o
);
    logic [15:0] w;
    logic [4:0] st_exp;
    logic [24:0] hold_ff;
    assign w = drive_status_word_o;
    // Expected {b6,b3,b2,b1,b0}
    always_comb begin
        case (op_state_i)
            ST_SWITCH_ON_DISABLED: st_exp = 5'h10;
            ST_READY: st_exp = 5'h01;
            ST_SWITCHED_ON: st_exp = 5'h03;
            ST_OP_ENABLED, ST_QUICK_STOP: st_exp = 5'h07;
            ST_FAULT_REACTION: st_exp = 5'h0F;
            ST_FAULT: st_exp = 5'h08;
            default: st_exp = 5'h00;
        endcase
    end
    // Cycles bit 7 has been high
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || !w[7]) begin
            hold_ff <= '0;
        end else if (hold_ff < 25'(WARN_HOLD_CYC)) begin
            hold_ff <= hold_ff + 25'h1;
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    chk_no_fault_out: assert property (!$past(sys_rst_i) |-> no_fault_o ==
        $past(op_state_i inside {ST_READY, ST_SWITCHED_ON, ST_OP_ENABLED}))
        else $error("no-fault output wrong");
    chk_active_out: assert property (!$past(sys_rst_i) |->
        second_digital_output_o == $past(op_state_i == ST_OP_ENABLED))
        else $error("active output wrong");
    chk_state_bits: assert property (!$past(sys_rst_i) |->
        {w[6], w[3:0]} == $past(st_exp)) else $error("state bits wrong");
    chk_qstop_bit: assert property (!$past(sys_rst_i) &&
        $past(op_state_i) inside {[ST_READY:ST_QUICK_STOP]} |->
        w[5] == $past(op_state_i != ST_QUICK_STOP)) else $error("bit 5 wrong");
    chk_volt_bit: assert property (!$past(sys_rst_i) |->
        w[4] == $past(dc_bus_ok_i)) else $error("bit 4 wrong");
    chk_allow_gate: assert property (!$past(sys_rst_i) |->
        allow_3_to_4_o == $past(req_3_to_4_i && dc_bus_ok_i &&
        op_state_i == ST_SWITCH_ON_DISABLED))
        else $error("transition allowed wrongly");
    chk_warn_set: assert property (!$past(sys_rst_i) &&
        $past(cond_i.warn_class0 && !cond_i.fault_reset) |-> w[7])
        else $error("bit 7 not set");
    chk_warn_hold: assert property ($fell(w[7]) |->
        $past(cond_i.fault_reset) || hold_ff >= 25'(WARN_HOLD_CYC - 1))
        else $error("bit 7 dropped early");
    chk_warn_clear: assert property (!$past(sys_rst_i) &&
        $past(cond_i.fault_reset) |-> !w[7]) else $error("bit 7 not cleared");
    chk_plain_bits: assert property (!$past(sys_rst_i) |->
        {w[15], w[13:12], w[10:8]} == $past({cond_i.zero_point_valid,
        cond_i.err_blocking, cond_i.mode_bit_b, cond_i.mode_bit_a,
        cond_i.remote, cond_i.halt_active})) else $error("plain bits wrong");
    chk_limit_select: assert property (!$past(sys_rst_i) |->
        w[11] == $past(internal_limit_meaning_select_i ?
        cond_i.limit_cond_b : cond_i.limit_cond_a)) else $error("bit 11 wrong");
    chk_end_drop: assert property (!$past(sys_rst_i) &&
        $past(cond_i.mode_start) |-> !w[14]) else $error("bit 14 not dropped");
    chk_end_rise: assert property (!$past(sys_rst_i, 2) && $rose(w[14]) |->
        $past(cond_i.standstill && !cond_i.new_mode_start))
        else $error("bit 14 rose wrongly");
    chk_read_valid: assert property (!$past(sys_rst_i) |->
        rd_valid_o == $past(rd_en_i)) else $error("read valid wrong");
endmodule
bind drive_state_status_word drive_status_monitor i_drive_status_monitor (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .op_state_i(op_state_i),
    .cond_i(cond_i),
    .dc_bus_ok_i(dc_bus_ok_i),
    .internal_limit_meaning_select_i(internal_limit_meaning_select_i),
    .req_3_to_4_i(req_3_to_4_i),
    .rd_en_i(rd_en_i),
    .allow_3_to_4_o(allow_3_to_4_o),
    .no_fault_o(no_fault_o),
    .second_digital_output_o(second_digital_output_o),
    .drive_status_word_o(drive_status_word_o),
    .rd_valid_o(rd_valid_o)
);

/* File: sim/status_reader.sv */
// Purpose: Fieldbus master model reading the status word
// Assumes: Reads are one-cycle strobes
// Notes: Address shows inverse pattern when released
`timescale 1ns/1ps
module status_reader (
    input wire logic sys_clk_i,
    output logic rd_en_o,
    output logic [15:0] rd_addr_o
);
    initial begin
        rd_en_o = 1'b0;
        rd_addr_o = 16'h0000;
    end
    task automatic read(input logic [15:0] addr);
        @(posedge sys_clk_i);
        #1;
        rd_en_o = 1'b1;
        rd_addr_o = addr;
        @(posedge sys_clk_i);
        #1;
        rd_en_o = 1'b0;
        rd_addr_o = ~addr;
    endtask
endmodule

/* File: sim/test_drive_state_status_word.sv */
// Purpose: Self-checking bench for the status word block
// Assumes: 200 MHz clock, sync reset
// Notes: Expected-value queue checked on each read result
`timescale 1ns/1ps
module test_drive_state_status_word;
    import drive_status_pkg::*;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    op_state_t st = ST_START;
    status_cond_t c = '0;
    logic dcok = 1'b0, sel = 1'b0, req = 1'b0, rd_en, rv, allow, nf, act;
    logic e7 = 1'b0, e14 = 1'b1;
    logic [15:0] rd_addr, sw, rd;
    logic [34:0] exp_q[$];
    int mismatches = 0, cmp_count = 0, seed = 32'h08CDCEBB;
    always #2.5 sys_clk_i = ~sys_clk_i;
    drive_state_status_word i_drive_state_status_word (.sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i), .op_state_i(st), .cond_i(c),
        .dc_bus_ok_i(dcok), .internal_limit_meaning_select_i(sel),
        .req_3_to_4_i(req), .rd_addr_i(rd_addr), .rd_en_i(rd_en),
        .allow_3_to_4_o(allow), .no_fault_o(nf),
        .second_digital_output_o(act), .drive_status_word_o(sw),
        .rd_data_o(rd), .rd_valid_o(rv));
    status_reader i_status_reader (.sys_clk_i(sys_clk_i), .rd_en_o(rd_en),
        .rd_addr_o(rd_addr));
    task automatic step();
        @(posedge sys_clk_i);
        #1;
    endtask
    task automatic check(input logic [15:0] addr);
        logic [15:0] w;
        w = {c.zero_point_valid, e14, c.err_blocking, c.mode_bit_b,
            sel ? c.limit_cond_b : c.limit_cond_a, c.mode_bit_a, c.remote,
            c.halt_active, e7, st == ST_SWITCH_ON_DISABLED,
            st inside {[ST_READY:ST_OP_ENABLED]}, dcok,
            st inside {ST_FAULT_REACTION, ST_FAULT},
            st inside {[ST_OP_ENABLED:ST_FAULT_REACTION]},
            st inside {[ST_SWITCHED_ON:ST_FAULT_REACTION]},
            st inside {[ST_READY:ST_FAULT_REACTION]}};
        repeat (2) @(posedge sys_clk_i);
        exp_q.push_back({req && dcok && st == ST_SWITCH_ON_DISABLED, w[5],
            st == ST_OP_ENABLED, w, addr == 16'h1B04 ? w : 16'h0000});
        i_status_reader.read(addr);
    endtask
    always @(negedge sys_clk_i) begin
        if (rv === 1'b1) begin
            cmp_count++;
            if ({allow, nf, act, sw, rd} !== exp_q[0]) begin
                mismatches++;
                $display("[FAIL] status read exp %h got %h", exp_q[0],
                    {allow, nf, act, sw, rd});
            end
            void'(exp_q.pop_front());
        end
    end
    task automatic end_of_test();
        if (exp_q.size() != 0) begin
            mismatches++;
            $display("[FAIL] pending reads exp 0 got %0d", exp_q.size());
        end
        $display("Compares %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        #15000;
        mismatches++;
        end_of_test();
    end
    initial begin
        repeat (6) step();
        sys_rst_i = 1'b0;
        for (int i = 1; i < 10; i++) begin
            for (int j = 0; j < 4; j++) begin
                st = op_state_t'(4'(i));
                c = status_cond_t'(14'($random(seed)) & 14'h0FE3);
                sel = 1'($random(seed));
                dcok = j[0];
                req = j[1];
                check(16'h1B04);
            end
        end
        check(16'h1B06);
        $display("state sweep done");
        c = '0;
        st = ST_OP_ENABLED;
        c.warn_class0 = 1'b1;
        e7 = 1'b1;
        check(16'h1B04);
        c.warn_class0 = 1'b0;
        check(16'h1B04);
        c.fault_reset = 1'b1;
        step();
        c.fault_reset = 1'b0;
        e7 = 1'b0;
        check(16'h1B04);
        $display("warning bit done");
        c.mode_start = 1'b1;
        step();
        c.mode_start = 1'b0;
        c.mode_stop = 1'b1;
        e14 = 1'b0;
        step();
        c.mode_stop = 1'b0;
        check(16'h1B04);
        c.standstill = 1'b1;
        e14 = 1'b1;
        check(16'h1B04);
        c.mode_start = 1'b1;
        step();
        c.mode_start = 1'b0;
        c.mode_stop = 1'b1;
        c.new_mode_start = 1'b1;
        e14 = 1'b0;
        step();
        c.mode_stop = 1'b0;
        check(16'h1B04);
        $display("end bit done");
        c = '0;
        c.warn_class0 = 1'b1;
        step();
        c.warn_class0 = 1'b0;
        sys_rst_i = 1'b1;
        repeat (2) step();
        sys_rst_i = 1'b0;
        e7 = 1'b0;
        e14 = 1'b1;
        check(16'h1B04);
        $display("mid-run reset done");
        repeat (4) step();
        end_of_test();
    end
endmodule
